// ==== plw_consts.svh ====
`ifndef PLW_CONSTS_SVH
`define PLW_CONSTS_SVH
// register byte offsets
`define PLW_ADDR_LOCK 8'h00
`define PLW_ADDR_CMP 8'h04
`define PLW_ADDR_PUMP 8'h08
`define PLW_ADDR_STAT 8'h0C
`define PLW_ADDR_ISTAT 8'h10
`define PLW_ADDR_IMASK 8'h14
// lock control fields
`define PLW_LK_CNT_LSB 0
`define PLW_LK_EN 3
`define PLW_LK_SRC 6
`define PLW_LK_DIV_LSB 7
`define PLW_LK_SPD_LSB 10
// comparator control fields
`define PLW_CMP_POL 4
`define PLW_CMP_UPEN 5
`define PLW_CMP_DNEN 6
`define PLW_CMP_SLIP_LSB 7
// interrupt bits
`define PLW_IRQ_GAIN 0
`define PLW_IRQ_LOSS 1
`define PLW_IRQ_SLIP 2
// reset values
`define PLW_RST_LOCK 12'h000
`define PLW_RST_CMP 9'h060
`define PLW_RST_PUMP 23'h000000
// timing
`define PLW_CLK_MHZ 20
`define PLW_AWIN_NS 10
`define PLW_RUN_BASE 14'h0040
`define PLW_SLIP_BASE 10'h004
`endif

// ==== plw_pkg.sv ====
package plw_pkg;
  // window evaluation states
  typedef enum logic [2:0] {
    PLW_IDLE = 3'b001,
    PLW_OPEN = 3'b010,
    PLW_LATE = 3'b100
  } plw_state_type;
  // pump gain and offset settings
  typedef struct packed {
    logic dn_off_en;
    logic up_off_en;
    logic [6:0] offset;
    logic [6:0] gain_b;
    logic [6:0] gain_a;
  } plw_pump_type;
  // pump command pair
  typedef struct packed {
    logic up;
    logic down;
  } plw_cmd_type;
endpackage : plw_pkg

// ==== plw_lock_window.sv ====
// How it works
// - window opens on whichever edge first
// - divider 0..7 gives 0.5..64 timer periods
// - speed 00 shortest period, 11 longest
// - polarity bit swaps up and down
// - both enables low means no pulses
// - two seven-bit pump gain fields
// - offset magnitude with up/down enables
// - large phase error raises comparator gain
// - lock enable gates all lock evaluation
// - source bit picks fixed or timer window
// - lock after consecutive hits, one miss clears
//
// Decided for this implementation: the register offsets and the APB register port.
`timescale 1ns/1ps
`include "plw_consts.svh"
module plw_lock_window
  import plw_pkg::*;
#(
  parameter int RUN_W = 14
) (
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // divided reference and feedback edges
  input wire logic ref_in,
  input wire logic fb_in,
  // current pump drive
  output plw_cmd_type pump_cmd,
  output logic gain_boost,
  output plw_pump_type pump_cfg,
  // status
  output logic lock_indicator,
  output logic irq
);
  // fixed analog window, rounded down, at least one cycle
  localparam int AWIN_RAW = (`PLW_AWIN_NS * `PLW_CLK_MHZ) / 1000;
  localparam int AWIN_INT = (AWIN_RAW < 1) ? 1 : AWIN_RAW;
  localparam logic [9:0] AWIN = 10'(AWIN_INT);

  // register storage
  logic [11:0] lock_ctrl;
  logic [8:0] cmp_ctrl;
  logic [2:0] int_stat;
  logic [2:0] int_mask;

  // synchroniser stages and detected edges
  logic ref_s1;
  logic ref_s2;
  logic ref_s3;
  logic fb_s1;
  logic fb_s2;
  logic fb_s3;
  logic ref_rise;
  logic fb_rise;

  // window tracking
  plw_state_type state;
  logic first_ref;
  logic [9:0] win_cnt;
  logic [9:0] win_len;
  logic other_edge;
  logic hit;
  logic miss;

  // consecutive-hit run
  logic [RUN_W-1:0] run;
  logic [RUN_W-1:0] run_goal;
  logic lock_set;

  // comparator and slip guard
  logic up_st;
  logic dn_st;
  logic next_up;
  logic next_dn;
  logic [9:0] err_cnt;
  logic [9:0] slip_lim;
  logic slip_rise;

  // bus strobes and interrupt events
  logic wr_en;
  logic setup;
  logic [2:0] ev;

  // field views
  logic lk_en;
  logic lk_src;
  logic [2:0] lk_cnt;
  logic [2:0] lk_div;
  logic [1:0] lk_spd;
  logic pol;
  logic up_en;
  logic dn_en;
  logic [1:0] slip_sel;
  assign lk_cnt = lock_ctrl[`PLW_LK_CNT_LSB +: 3];
  assign lk_en = lock_ctrl[`PLW_LK_EN];
  assign lk_src = lock_ctrl[`PLW_LK_SRC];
  assign lk_div = lock_ctrl[`PLW_LK_DIV_LSB +: 3];
  assign lk_spd = lock_ctrl[`PLW_LK_SPD_LSB +: 2];
  assign pol = cmp_ctrl[`PLW_CMP_POL];
  assign up_en = cmp_ctrl[`PLW_CMP_UPEN];
  assign dn_en = cmp_ctrl[`PLW_CMP_DNEN];
  assign slip_sel = cmp_ctrl[`PLW_CMP_SLIP_LSB +: 2];

  // apb strobes, zero wait states
  assign setup = psel & ~penable;
  assign wr_en = psel & penable & pwrite;
  assign pready = psel & penable;

  // control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_ctrl <= `PLW_RST_LOCK;
      cmp_ctrl <= `PLW_RST_CMP;
      pump_cfg <= `PLW_RST_PUMP;
      int_mask <= 3'h0;
    end else if (wr_en) begin
      unique case (paddr)
        `PLW_ADDR_LOCK: lock_ctrl <= pwdata[11:0];
        `PLW_ADDR_CMP: cmp_ctrl <= pwdata[8:0];
        `PLW_ADDR_PUMP: pump_cfg <= pwdata[22:0];
        `PLW_ADDR_IMASK: int_mask <= pwdata[2:0];
        default: ;
      endcase
    end
  end

  // read data and error captured in setup phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup) begin
      pslverr <= 1'b0;
      unique case (paddr)
        `PLW_ADDR_LOCK: prdata <= {20'h00000, lock_ctrl};
        `PLW_ADDR_CMP: prdata <= {23'h000000, cmp_ctrl};
        `PLW_ADDR_PUMP: prdata <= {9'h000, pump_cfg};
        `PLW_ADDR_STAT: prdata <= {29'h0, state == PLW_IDLE, gain_boost, lock_indicator};
        `PLW_ADDR_ISTAT: prdata <= {29'h0, int_stat};
        `PLW_ADDR_IMASK: prdata <= {29'h0, int_mask};
        default: begin
          prdata <= 32'h0000_0000;
          pslverr <= 1'b1;
        end
      endcase
    end
  end

  // two-stage synchronisers plus edge history
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_s1 <= 1'b0;
      ref_s2 <= 1'b0;
      ref_s3 <= 1'b0;
      fb_s1 <= 1'b0;
      fb_s2 <= 1'b0;
      fb_s3 <= 1'b0;
    end else begin
      ref_s1 <= ref_in;
      ref_s2 <= ref_s1;
      ref_s3 <= ref_s2;
      fb_s1 <= fb_in;
      fb_s2 <= fb_s1;
      fb_s3 <= fb_s2;
    end
  end
  assign ref_rise = ref_s2 & ~ref_s3;
  assign fb_rise = fb_s2 & ~fb_s3;

  // window length in cycles; half a timer period is spd+1 cycles
  always_comb begin
    if (lk_src) begin
      win_len = (10'({1'b0, lk_spd}) + 10'h001) << lk_div;
    end else begin
      win_len = AWIN;
    end
  end

  // edge that closes the window
  assign other_edge = first_ref ? fb_rise : ref_rise;

  // hit and miss of one comparison cycle
  always_comb begin
    hit = 1'b0;
    miss = 1'b0;
    if (lk_en) begin
      unique case (state)
        // simultaneous edges count as in-window
        PLW_IDLE: hit = ref_rise & fb_rise;
        PLW_OPEN: begin
          // an edge landing as the count expires is already late
          hit = other_edge & (win_cnt < win_len);
          miss = (win_cnt >= win_len);
        end
        PLW_LATE: ;
      endcase
    end
  end

  // window state machine
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= PLW_IDLE;
      first_ref <= 1'b0;
      win_cnt <= 10'h000;
    end else if (!lk_en) begin
      state <= PLW_IDLE;
      win_cnt <= 10'h000;
    end else begin
      unique case (state)
        PLW_IDLE: begin
          if ((ref_rise ^ fb_rise)) begin
            state <= PLW_OPEN;
            first_ref <= ref_rise;
            win_cnt <= 10'h001;
          end
        end
        PLW_OPEN: begin
          // the closing edge ends the cycle, hit or miss
          if (other_edge) begin
            state <= PLW_IDLE;
          end else if (miss) begin
            state <= PLW_LATE;
          end else begin
            win_cnt <= win_cnt + 10'h001;
          end
        end
        PLW_LATE: begin
          if (other_edge) begin
            state <= PLW_IDLE;
          end
        end
      endcase
    end
  end

  // consecutive-hit goal: setting n needs 64 << n hits
  assign run_goal = RUN_W'(`PLW_RUN_BASE) << lk_cnt;
  // gain event only on the hit that completes the run
  assign lock_set = hit & ~lock_indicator & (run + 1'b1 >= run_goal);

  // lock declaration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run <= '0;
      lock_indicator <= 1'b0;
    end else if (!lk_en) begin
      run <= '0;
      lock_indicator <= 1'b0;
    end else if (miss) begin
      run <= '0;
      lock_indicator <= 1'b0;
    end else if (hit) begin
      if (run + 1'b1 >= run_goal) begin
        run <= run_goal;
        lock_indicator <= 1'b1;
      end else begin
        run <= run + 1'b1;
      end
    end
  end

  // comparator state: up on reference, down on feedback, both clear
  always_comb begin
    next_up = up_st | ref_rise;
    next_dn = dn_st | fb_rise;
    if (next_up & next_dn) begin
      next_up = 1'b0;
      next_dn = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      up_st <= 1'b0;
      dn_st <= 1'b0;
    end else begin
      up_st <= next_up;
      dn_st <= next_dn;
    end
  end

  // pump commands with polarity and enables
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pump_cmd <= '0;
    end else begin
      pump_cmd.up <= (pol ? next_dn : next_up) & up_en;
      pump_cmd.down <= (pol ? next_up : next_dn) & dn_en;
    end
  end

  // phase error length and slip guard boost
  assign slip_lim = `PLW_SLIP_BASE << slip_sel;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_cnt <= 10'h000;
      gain_boost <= 1'b0;
    end else if (next_up | next_dn) begin
      if (err_cnt != 10'h3FF) begin
        err_cnt <= err_cnt + 10'h001;
      end
      gain_boost <= (err_cnt >= slip_lim);
    end else begin
      err_cnt <= 10'h000;
      gain_boost <= 1'b0;
    end
  end
  // boost start event for the status register
  assign slip_rise = (next_up | next_dn) & (err_cnt >= slip_lim) & ~gain_boost;

  // interrupt events
  always_comb begin
    ev = 3'h0;
    ev[`PLW_IRQ_GAIN] = lock_set;
    ev[`PLW_IRQ_LOSS] = miss & lock_indicator;
    ev[`PLW_IRQ_SLIP] = slip_rise;
  end

  // sticky status, write one to clear, set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_stat <= 3'h0;
    end else if (wr_en && paddr == `PLW_ADDR_ISTAT) begin
      int_stat <= (int_stat & ~pwdata[2:0]) | ev;
    end else begin
      int_stat <= int_stat | ev;
    end
  end

  // level interrupt
  assign irq = |(int_stat & int_mask);
endmodule : plw_lock_window

// ==== plw_lock_window_sva.sv ====
`timescale 1ns/1ps
module plw_lock_window_sva
  import plw_pkg::*;
#(
  parameter int RUN_W = 14
) (
  // apb side
  input wire logic pclk, presetn, psel, penable, pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata, prdata,
  input wire logic pready, pslverr,
  // loop side
  input wire logic ref_in, fb_in, gain_boost, lock_indicator, irq,
  input wire plw_cmd_type pump_cmd,
  input wire plw_pump_type pump_cfg
);
  logic lk_en;
  logic [1:0] pen;
  wire wr_go = psel && penable && pwrite;
  // shadow of lock enable and pump enables
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lk_en <= 1'b0;
      pen <= 2'b11;
    end else if (wr_go && paddr == 8'h00) begin
      lk_en <= pwdata[3];
    end else if (wr_go && paddr == 8'h04) begin
      pen <= pwdata[6:5];
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ready_zero_a: assert property (psel && penable |-> pready)
    else $error("pready low in access");
  unmapped_err_a: assert property (psel && penable && paddr > 8'h14 |-> pslverr)
    else $error("no error on unmapped slot");
  unmapped_read_a: assert property (psel && penable && !pwrite && paddr > 8'h14 |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  cfg_write_a: assert property (wr_go && paddr == 8'h08 |=> pump_cfg == $past(pwdata[22:0]))
    else $error("pump settings not written");
  cfg_read_a: assert property (psel && penable && !pwrite && paddr == 8'h08 && $stable(pump_cfg)
    |-> prdata == {9'h0, pump_cfg})
    else $error("pump settings readback wrong");
  pump_quiet_a: assert property (pen == 2'b00 && $past(pen) == 2'b00 |-> pump_cmd == 2'b00)
    else $error("pump pulse while disabled");
  lock_gate_a: assert property (!lk_en [*3] |-> !lock_indicator)
    else $error("lock while disabled");
  boost_cause_a: assert property (pen == 2'b11 && $rose(gain_boost) |-> $past(pump_cmd) != 2'b00)
    else $error("boost without phase error");
  cover property ($rose(lock_indicator));
  cover property ($fell(lock_indicator));
  cover property ($rose(gain_boost));
endmodule : plw_lock_window_sva
bind plw_lock_window plw_lock_window_sva #(.RUN_W(RUN_W)) u_sva (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .ref_in(ref_in), .fb_in(fb_in),
  .gain_boost(gain_boost), .lock_indicator(lock_indicator), .irq(irq),
  .pump_cmd(pump_cmd), .pump_cfg(pump_cfg));

// ==== plw_loop_model.sv ====
`timescale 1ns/1ps
module plw_loop_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // reference period and feedback lag, in cycles
  input wire logic [7:0] period,
  input wire logic [7:0] skew,
  // divided reference and feedback
  output logic ref_in,
  output logic fb_in
);
  logic [7:0] ph;
  logic [8:0] fq;
  // reference phase accumulator
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ph <= 8'h00;
    end else begin
      ph <= (ph >= period - 8'h01) ? 8'h00 : ph + 8'h01;
    end
  end
  // feedback phase trails by skew, wrapped
  always_comb begin
    fq = {1'b0, ph} + {1'b0, period} - {1'b0, skew};
    if (fq >= {1'b0, period}) fq = fq - {1'b0, period};
  end
  // half-period square waves
  assign ref_in = ph < (period >> 1);
  assign fb_in = fq < {1'b0, period >> 1};
endmodule : plw_loop_model

// ==== plw_lock_window_bench.sv ====
`timescale 1ns/1ps
module plw_lock_window_bench;
  import plw_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00, period = 8'h10, skew = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, v;
  logic pready, pslverr, ref_in, fb_in, gain_boost, lock_indicator, irq, er;
  plw_cmd_type pump_cmd;
  plw_pump_type pump_cfg;
  int err_count = 0, num_checks = 0, ups, dns, bst, len, dv, sp;
  logic [31:0] cv [6] = '{32'h060, 32'h070, 32'h000, 32'h0E0, 32'h160, 32'h1E0};
  logic [2:0] ce [6] = '{3'b101, 3'b011, 3'b001, 3'b101, 3'b100, 3'b100};
  always #25 pclk = ~pclk;
  plw_loop_model u_loop (.pclk(pclk), .presetn(presetn), .period(period), .skew(skew),
    .ref_in(ref_in), .fb_in(fb_in));
  plw_lock_window u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ref_in(ref_in), .fb_in(fb_in), .pump_cmd(pump_cmd),
    .gain_boost(gain_boost), .pump_cfg(pump_cfg), .lock_indicator(lock_indicator), .irq(irq));
  // pump activity tally
  always @(posedge pclk) begin
    if (pump_cmd.up === 1'b1) ups++;
    if (pump_cmd.down === 1'b1) dns++;
    if (gain_boost === 1'b1) bst++;
  end
  function automatic logic [31:0] lk(input logic src, input int d, input int s);
    return {20'h0, 2'(s), 3'(d), src, 3'b001, 3'b000};
  endfunction : lk
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic lock_case(input logic [31:0] c, input int sk, input logic exp);
    skew <= 8'(sk);
    apb(1'b1, 8'h00, c);
    repeat (70 * period) @(posedge pclk);
    check(lock_indicator, exp);
  endtask : lock_case
  task automatic conclude();
    $display("checks=%0d errors=%0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : conclude
  initial begin
    #4000000;
    err_count++;
    conclude();
  end
  initial begin
    void'($urandom(15));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    // reset values, then an unmapped slot
    for (int i = 0; i < 7; i++) begin
      apb(1'b0, 8'(i * 4), 32'h0);
      check(rd, (i == 1) ? 32'h060 : (i == 3) ? 32'h4 : 32'h0);
      check(er, i == 6);
    end
    v = $urandom();
    apb(1'b1, 8'h08, v);
    apb(1'b0, 8'h08, 32'h0);
    check(rd, {9'h0, v[22:0]});
    check(pump_cfg, v[22:0]);
    dv = $urandom_range(2);
    sp = $urandom_range(3);
    len = (sp + 1) << dv;
    period <= 8'(4 * len + 8);
    apb(1'b1, 8'h14, 32'h3);
    lock_case(lk(1'b1, dv, sp), len - 1, 1'b1);
    check(irq, 1'b1);
    apb(1'b1, 8'h10, 32'h7);
    @(posedge pclk);
    check(irq, 1'b0);
    lock_case(lk(1'b1, dv, sp), 4 * len + 9 - len, 1'b1);
    lock_case(lk(1'b1, dv, sp), len, 1'b0);
    lock_case(lk(1'b1, dv, sp), len + 2, 1'b0);
    check(irq, 1'b1);
    apb(1'b1, 8'h14, 32'h0);
    @(posedge pclk);
    check(irq, 1'b0);
    apb(1'b1, 8'h10, 32'h7);
    lock_case(lk(1'b0, dv, sp), 0, 1'b1);
    lock_case(lk(1'b0, dv, sp) & 32'hFFFFFFF7, 0, 1'b0);
    lock_case(lk(1'b0, dv, sp) | 32'h1, 0, 1'b0);
    lock_case(lk(1'b0, dv, sp) | 32'h1, 0, 1'b1);
    lock_case(lk(1'b0, dv, sp), 3, 1'b0);
    // polarity, enables and every slip code
    period <= 8'd40;
    skew <= 8'd12;
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, 8'h04, cv[i]);
      repeat (80) @(posedge pclk);
      ups = 0;
      dns = 0;
      bst = 0;
      repeat (80) @(posedge pclk);
      check({ups != 0, dns != 0, bst != 0}, ce[i]);
    end
    conclude();
  end
endmodule : plw_lock_window_bench
